/* File: verilog/lcd_cfg_pkg.sv */
// package: register map, field layouts, reset values and decode types
//
// Overview of operation
// (R01) alt select bit steers second contrast write: 0 low contrast, 1 boost and bias
// (R02) five-bit contrast code; codes 0..7 give 2.5R, each step lowers 0.1R
// (R03) boost bit 0 requests doubling, 1 requests tripling
// (R04) bias code 00 one-fifth (reset), 01 quarter, 10 third, 11 half
// (R05) contrast code resets to zero, highest resistor 2.5R
// (R06) character mode fetches fonts from bank chosen by bank-select bit
// (R07) after each ram write address counter steps up if direction 1, else down
// (R08) cursor and blink position move right on increment, left on decrement
// (R09) segment blink off uses upper nibble only; on uses all eight bits
// (R10) host sets segment blink enable whenever character mode is configured
// (R11) inversion cursor with line cursor off blinks inverted at chosen period
// (R12) inversion and line cursor both set: whole cursor line inverted steadily
// (R13) underline cursor bit ors five-dot bar onto eighth raster row
// (R14) blink cursor alternates with black, or white when inversion set; the code blinks only in character mode (line code bit 2 set)
// (R15) display off grounds segments and commons, keeps ram; on restores immediately
// (R16) blink phase toggles every 32 frames, or 64 with period bit set
// (R17) line cursor applies cursor attribute to the line holding the address
// (R18) line count decode: 2,3,4 duty, 1/11, 1/18; 101 resets; 011 inhibited
// (R19) ram address mapping independent of selected line count
// (R20) code 110 mirrors fonts on second line only
// (R21) double height bit stretches the first line to double height
// (R22) host inserts no spacing between lines when double height used
// (R23) every configuration write completes at once, back to back allowed
// (R24) first contrast write gives select and upper bits, second the rest
// (R25) every field holds until rewritten and resets to its initial value
package lcd_cfg_pkg;

    // register byte offsets
    localparam logic [7:0] contrast1_offset = 8'h00;
    localparam logic [7:0] contrast2_offset = 8'h04;
    localparam logic [7:0] entry_mode_offset = 8'h08;
    localparam logic [7:0] cursor_ctrl_offset = 8'h0c;
    localparam logic [7:0] display_ctrl_offset = 8'h10;
    localparam logic [7:0] line_ctrl_offset = 8'h14;
    localparam logic [7:0] double_height_offset = 8'h18;
    localparam logic [7:0] ram_write_offset = 8'h1c;
    localparam logic [7:0] frame_tick_offset = 8'h20;
    localparam logic [7:0] status_offset = 8'h24;
    localparam logic [7:0] decode_offset = 8'h28;

    // reset values
    localparam logic [4:0] contrast_reset = 5'h00;
    localparam logic [1:0] bias_reset = 2'h0;
    localparam logic [2:0] line_count_reset = 3'h5;
    localparam logic [6:0] address_reset = 7'h00;

    // line-count codes
    localparam logic [2:0] lines_duty2 = 3'h0;
    localparam logic [2:0] lines_duty3 = 3'h1;
    localparam logic [2:0] lines_duty4 = 3'h2;
    localparam logic [2:0] lines_inhibit = 3'h3;
    localparam logic [2:0] lines_one_char = 3'h4;
    localparam logic [2:0] lines_two_char = 3'h5;
    localparam logic [2:0] lines_two_mirror = 3'h6;

    // contrast steps: codes up to this one all give the top resistor value
    localparam logic [4:0] contrast_flat_top = 5'h07;
    localparam logic [4:0] resistor_top_tenths = 5'h19;
    localparam logic [5:0] blink_frames_short = 6'h1f;
    localparam logic [5:0] blink_frames_long = 6'h3f;
    localparam logic [6:0] line_span = 7'h20;

    // axi response codes
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef struct packed {
        logic alt_field_select;
        logic [4:0] contrast_code;
        logic boost_factor;
        logic [1:0] bias_code;
        logic font_bank;
        logic address_direction;
        logic segment_blink_enable;
        logic invert_cursor;
        logic underline_cursor;
        logic blink_cursor;
        logic display_on;
        logic blink_period;
        logic line_cursor;
        logic [2:0] line_count_field;
        logic double_height;
    } config_type;

    typedef struct packed {
        logic [4:0] resistor_tenths;
        logic triple_boost;
        logic [2:0] bias_divisor;
        logic [4:0] duty_divisor;
        logic char_mode;
        logic mirror_second_line;
        logic double_first_line;
        logic drive_enable;
        logic segment_full_byte;
        logic invert_line;
        logic invert_blink;
        logic underline_row8;
        logic blink_black;
        logic blink_white;
    } drive_type;

endpackage

/* File: verilog/lcd_display_config_decoder.sv */
// top module: axi4-lite configuration decoder for the lcd drive settings
`timescale 1ns/1ps
`default_nettype none
module lcd_display_config_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output lcd_cfg_pkg::config_type cfg,
    output lcd_cfg_pkg::drive_type drive,
    output logic [6:0] address_counter,
    output logic blink_phase
);
    import lcd_cfg_pkg::*;

    ////////////////////////////////////////
    // decode helpers

    // resistor in tenths of r: flat for low codes, then one tenth per step
    function automatic logic [4:0] resistor_of(input logic [4:0] code);
        if (code <= contrast_flat_top) begin
            resistor_of = resistor_top_tenths; // [R02]
        end else begin
            resistor_of = 5'(resistor_top_tenths - (code - contrast_flat_top)); // [R02]
        end
    endfunction

    // duty denominator from line-count code; inhibited code reads as zero
    function automatic logic [4:0] duty_of(input logic [2:0] code);
        case (code)
            lines_duty2: duty_of = 5'h02; // [R18]
            lines_duty3: duty_of = 5'h03;
            lines_duty4: duty_of = 5'h04;
            lines_one_char: duty_of = 5'h0b;
            lines_two_char: duty_of = 5'h12;
            lines_two_mirror: duty_of = 5'h12;
            default: duty_of = 5'h00;
        endcase
    endfunction

    ////////////////////////////////////////
    // axi write channel state

    typedef enum logic [2:0] {
        w_idle = 3'b001,
        w_collect = 3'b010,
        w_resp = 3'b100
    } wstate_type;

    wstate_type wstate_reg, wstate_next;
    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [7:0] waddr_reg, waddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic do_write;

    // configuration state
    config_type cfg_reg, cfg_next;
    logic [6:0] ac_reg, ac_next;
    logic [5:0] frame_cnt_reg, frame_cnt_next;
    logic phase_reg, phase_next;
    drive_type drive_reg, drive_next;

    // address and data are taken independently; the write lands when both are held
    always_comb begin
        wstate_next = wstate_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        awready_next = awready_reg;
        wready_next = wready_reg;
        do_write = 1'b0;
        case (wstate_reg)
            w_idle: begin
                awready_next = 1'b1;
                wready_next = 1'b1;
                wstate_next = w_collect;
            end
            w_collect: begin
                if (s_axi_awvalid && awready_reg) begin
                    aw_have_next = 1'b1;
                    waddr_next = s_axi_awaddr;
                    awready_next = 1'b0;
                end
                if (s_axi_wvalid && wready_reg) begin
                    w_have_next = 1'b1;
                    wdata_next = s_axi_wdata;
                    wstrb_next = s_axi_wstrb;
                    wready_next = 1'b0;
                end
                if (aw_have_reg && w_have_reg) begin
                    do_write = 1'b1;
                    aw_have_next = 1'b0;
                    w_have_next = 1'b0;
                    bvalid_next = 1'b1;
                    bresp_next = resp_okay;
                    if (waddr_reg > frame_tick_offset || waddr_reg[1:0] != 2'h0) begin
                        bresp_next = resp_slverr;
                    end
                    wstate_next = w_resp;
                end
            end
            w_resp: begin
                if (s_axi_bready) begin
                    bvalid_next = 1'b0;
                    awready_next = 1'b1;
                    wready_next = 1'b1;
                    wstate_next = w_collect;
                end
            end
            default: begin
                wstate_next = w_idle;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_reg <= w_idle;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= resp_okay;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
        end else begin
            wstate_reg <= wstate_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
        end
    end

    ////////////////////////////////////////
    // configuration fields, address counter and blink counter

    // every write with byte lane 0 strobed is applied in the cycle it lands, no busy time [R23]
    always_comb begin
        cfg_next = cfg_reg; // fields hold until rewritten [R25]
        ac_next = ac_reg;
        frame_cnt_next = frame_cnt_reg;
        phase_next = phase_reg;
        if (do_write && wstrb_reg[0]) begin
            case (waddr_reg)
                contrast1_offset: begin
                    cfg_next.alt_field_select = wdata_reg[2]; // [R24]
                    cfg_next.contrast_code[4:3] = wdata_reg[1:0]; // [R24]
                end
                contrast2_offset: begin
                    if (cfg_reg.alt_field_select) begin // [R01]
                        cfg_next.boost_factor = wdata_reg[2]; // [R24]
                        cfg_next.bias_code = wdata_reg[1:0];
                    end else begin
                        cfg_next.contrast_code[2:0] = wdata_reg[2:0]; // [R01]
                    end
                end
                entry_mode_offset: begin
                    cfg_next.font_bank = wdata_reg[2];
                    cfg_next.address_direction = wdata_reg[1];
                    cfg_next.segment_blink_enable = wdata_reg[0];
                end
                cursor_ctrl_offset: begin
                    cfg_next.invert_cursor = wdata_reg[2];
                    cfg_next.underline_cursor = wdata_reg[1];
                    cfg_next.blink_cursor = wdata_reg[0];
                end
                display_ctrl_offset: begin
                    cfg_next.display_on = wdata_reg[2];
                    cfg_next.blink_period = wdata_reg[1];
                    cfg_next.line_cursor = wdata_reg[0];
                end
                line_ctrl_offset: begin
                    cfg_next.line_count_field = wdata_reg[2:0]; // [R18]
                end
                double_height_offset: begin
                    cfg_next.double_height = wdata_reg[0];
                end
                ram_write_offset: begin
                    // cursor follows the counter: right on up, left on down [R08]
                    if (cfg_reg.address_direction) begin
                        ac_next = 7'(ac_reg + 7'h01); // [R07]
                    end else begin
                        ac_next = 7'(ac_reg - 7'h01); // [R07]
                    end
                end
                frame_tick_offset: begin
                    // terminal count depends on the blink period bit [R16]
                    if (frame_cnt_reg == (cfg_reg.blink_period ? blink_frames_long
                                                               : blink_frames_short)) begin
                        frame_cnt_next = 6'h00;
                        phase_next = ~phase_reg; // [R16]
                    end else begin
                        frame_cnt_next = 6'(frame_cnt_reg + 6'h01);
                    end
                end
                default: begin
                    ac_next = ac_reg;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= '0; // [R25]
            cfg_reg.contrast_code <= contrast_reset; // [R05]
            cfg_reg.bias_code <= bias_reset; // [R04]
            cfg_reg.line_count_field <= line_count_reset; // [R18]
            cfg_reg.address_direction <= 1'b1;
            ac_reg <= address_reset;
            frame_cnt_reg <= 6'h00;
            phase_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            ac_reg <= ac_next;
            frame_cnt_reg <= frame_cnt_next;
            phase_reg <= phase_next;
        end
    end

    ////////////////////////////////////////
    // registered drive decode for the analogue and display pipeline

    always_comb begin
        drive_next.resistor_tenths = resistor_of(cfg_reg.contrast_code); // [R02]
        drive_next.triple_boost = cfg_reg.boost_factor; // [R03]
        case (cfg_reg.bias_code) // [R04]
            2'h0: drive_next.bias_divisor = 3'h5;
            2'h1: drive_next.bias_divisor = 3'h4;
            2'h2: drive_next.bias_divisor = 3'h3;
            default: drive_next.bias_divisor = 3'h2;
        endcase
        drive_next.duty_divisor = duty_of(cfg_reg.line_count_field); // [R18]
        // ram mapping is not touched by the line count [R19]
        drive_next.char_mode = cfg_reg.line_count_field[2]; // [R06]
        drive_next.mirror_second_line = (cfg_reg.line_count_field == lines_two_mirror); // [R20]
        drive_next.double_first_line = cfg_reg.double_height; // [R21]
        drive_next.drive_enable = cfg_reg.display_on; // [R15]
        drive_next.segment_full_byte = cfg_reg.segment_blink_enable; // [R09]
        // steady line inversion overrides the blinking one [R12]
        drive_next.invert_line = cfg_reg.invert_cursor && cfg_reg.line_cursor; // [R12]
        drive_next.invert_blink = cfg_reg.invert_cursor && !cfg_reg.line_cursor
                                  && phase_reg; // [R11]
        drive_next.underline_row8 = cfg_reg.underline_cursor; // [R13]
        drive_next.blink_black = cfg_reg.blink_cursor && !cfg_reg.invert_cursor
                                 && cfg_reg.line_count_field[2] && phase_reg; // [R14]
        drive_next.blink_white = cfg_reg.blink_cursor && cfg_reg.invert_cursor
                                 && cfg_reg.line_count_field[2] && phase_reg; // [R14]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_reg <= '0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    ////////////////////////////////////////
    // axi read channel: one outstanding read, answered the cycle after arrival

    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_next = 1'b0;
                arready_next = 1'b1;
            end
        end else if (!arready_reg) begin
            arready_next = 1'b1;
        end else if (s_axi_arvalid) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = resp_okay;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr)
                contrast1_offset: rdata_next[2:0] = {cfg_reg.alt_field_select,
                                                     cfg_reg.contrast_code[4:3]};
                contrast2_offset: rdata_next[2:0] = cfg_reg.alt_field_select
                    ? {cfg_reg.boost_factor, cfg_reg.bias_code} : cfg_reg.contrast_code[2:0];
                entry_mode_offset: rdata_next[2:0] = {cfg_reg.font_bank,
                    cfg_reg.address_direction, cfg_reg.segment_blink_enable};
                cursor_ctrl_offset: rdata_next[2:0] = {cfg_reg.invert_cursor,
                    cfg_reg.underline_cursor, cfg_reg.blink_cursor};
                display_ctrl_offset: rdata_next[2:0] = {cfg_reg.display_on,
                    cfg_reg.blink_period, cfg_reg.line_cursor};
                line_ctrl_offset: rdata_next[2:0] = cfg_reg.line_count_field;
                double_height_offset: rdata_next[0] = cfg_reg.double_height;
                ram_write_offset: rdata_next = 32'h0000_0000;
                frame_tick_offset: rdata_next[5:0] = frame_cnt_reg;
                status_offset: rdata_next[14:0] = {ac_reg / line_span, phase_reg, ac_reg};
                decode_offset: rdata_next[14:0] = {drive_reg.duty_divisor,
                    drive_reg.bias_divisor, drive_reg.triple_boost,
                    drive_reg.resistor_tenths, drive_reg.mirror_second_line};
                default: rresp_next = resp_slverr;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= resp_okay;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign cfg = cfg_reg;
    assign drive = drive_reg;
    assign address_counter = ac_reg; // line of cursor is ac/32, attribute applied there [R17]
    assign blink_phase = phase_reg;

endmodule
`default_nettype wire

/* File: verification/lcd_cfg_asserts.sv */
// checker: bus timing and decode relations at the decoder ports
`timescale 1ns/1ps
`default_nettype none
module lcd_cfg_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire lcd_cfg_pkg::config_type cfg,
    input wire lcd_cfg_pkg::drive_type drive,
    input wire logic [6:0] address_counter
);
    import lcd_cfg_pkg::*;
    logic [1:0] warm_reg;
    // decode trails cfg by a cycle: skip edges just after reset
    always_ff @(posedge aclk) warm_reg <= aresetn ? warm_reg + 2'(warm_reg != 2'h3) : 2'h0;
    wire ok = (warm_reg == 2'h3);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    AST_WRITE_B: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RESISTOR: assert property (ok |-> drive.resistor_tenths ==
        (($past(cfg.contrast_code) <= 5'h07) ? 5'h19 : 5'h00 - $past(cfg.contrast_code)))
        else $error("resistor decode wrong");
    AST_BOOST: assert property (ok |-> drive.triple_boost == $past(cfg.boost_factor))
        else $error("boost decode wrong");
    AST_BIAS: assert property (
        ok |-> drive.bias_divisor == 3'h5 - {1'b0, $past(cfg.bias_code)})
        else $error("bias decode wrong");
    AST_DRIVE_EN: assert property (ok |-> drive.drive_enable == $past(cfg.display_on))
        else $error("drive enable wrong");
    AST_MIRROR: assert property (
        ok |-> drive.mirror_second_line == ($past(cfg.line_count_field) == 3'h6))
        else $error("mirror decode wrong");
    AST_LINE_INV: assert property (
        ok |-> drive.invert_line == ($past(cfg.invert_cursor) && $past(cfg.line_cursor)))
        else $error("line invert wrong");
    AST_AC_STEP: assert property (ok && $changed(address_counter) |->
        address_counter == ($past(cfg.address_direction) ?
        $past(address_counter) + 7'h1 : $past(address_counter) - 7'h1))
        else $error("counter step wrong");
endmodule
`default_nettype wire

/* File: verification/lcd_host_model.sv */
// host model: axi4-lite master for configuration writes and reads
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // idle bus at time zero; only full-word writes are issued
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // read held until taken, answer collected at the rvalid edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_lcd_display_config_decoder.sv */
// testbench: field writes, decode readback, counters and refusals
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_display_config_decoder;
    import lcd_cfg_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [14:0] dec;
    } row_type;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic blink_phase, start_phase;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [6:0] address_counter;
    config_type cfg;
    drive_type drive;
    int num_errors = 0;
    int cmp_count = 0;
    // write, then decode word expected afterwards
    row_type rows [0:15] = '{
        '{8'h00, 32'h3, 15'h4a90}, '{8'h04, 32'h7, 15'h4a82}, '{8'h00, 32'h1, 15'h4aa2},
        '{8'h04, 32'h0, 15'h4ab0}, '{8'h00, 32'h4, 15'h4ab2}, '{8'h04, 32'h7, 15'h4972},
        '{8'h04, 32'h2, 15'h49b2}, '{8'h04, 32'h1, 15'h4a32}, '{8'h14, 32'h0, 15'h0a32},
        '{8'h14, 32'h1, 15'h0e32}, '{8'h14, 32'h2, 15'h1232}, '{8'h14, 32'h4, 15'h2e32},
        '{8'h14, 32'h6, 15'h4a33}, '{8'h00, 32'h0, 15'h4a33}, '{8'h04, 32'h7, 15'h4a33},
        '{8'h00, 32'h1, 15'h4a23}
    };
    lcd_display_config_decoder u_lcd_display_config_decoder (.*);
    lcd_host_model u_host (.*);
    // 50 MHz bus clock
    always #10 aclk = ~aclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // a stalled handshake ends here rather than hanging
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        results();
    end
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.rd(decode_offset, rd_data, resp);
        chk("reset decode", 32'h4ab2, rd_data);
        chk("reset lines", 32'h5, {29'h0, cfg.line_count_field});
        $display("test reset done");
        u_host.wr(entry_mode_offset, 32'h3, resp);
        foreach (rows[i]) begin
            u_host.wr(rows[i].addr, rows[i].data, resp);
            chk("write resp", 32'h0, {30'h0, resp});
            u_host.rd(decode_offset, rd_data, resp);
            chk("decode", {17'h0, rows[i].dec}, rd_data);
        end
        $display("test rows done");
        // counter steps up twice, then down once
        u_host.wr(ram_write_offset, 32'h0, resp);
        u_host.wr(ram_write_offset, 32'h0, resp);
        @(negedge aclk);
        chk("counter up", 32'h2, {25'h0, address_counter});
        u_host.wr(entry_mode_offset, 32'h1, resp);
        u_host.wr(ram_write_offset, 32'h0, resp);
        @(negedge aclk);
        chk("counter down", 32'h1, {25'h0, address_counter});
        u_host.wr(cursor_ctrl_offset, 32'h4, resp);
        u_host.wr(double_height_offset, 32'h1, resp);
        u_host.wr(display_ctrl_offset, 32'h5, resp);
        @(negedge aclk);
        chk("line invert", 32'h1, {31'h0, drive.invert_line});
        chk("display on", 32'h1, {31'h0, drive.drive_enable});
        u_host.wr(display_ctrl_offset, 32'h0, resp);
        @(negedge aclk);
        chk("display off", 32'h0, {31'h0, drive.drive_enable});
        $display("test cursor done");
        // short period: phase holds 31 ticks, flips on the 32nd
        start_phase = blink_phase;
        repeat (31) u_host.wr(frame_tick_offset, 32'h0, resp);
        @(negedge aclk);
        chk("phase held", {31'h0, start_phase}, {31'h0, blink_phase});
        u_host.wr(frame_tick_offset, 32'h0, resp);
        repeat (2) @(negedge aclk);
        chk("phase flip", {31'h0, ~start_phase}, {31'h0, blink_phase});
        chk("invert blink", {31'h0, ~start_phase}, {31'h0, drive.invert_blink});
        u_host.wr(8'h40, 32'h7, resp);
        chk("bad write", {30'h0, resp_slverr}, {30'h0, resp});
        u_host.rd(8'h40, rd_data, resp);
        chk("bad read", {30'h0, resp_slverr}, {30'h0, resp});
        u_host.wr(decode_offset, 32'h0, resp);
        u_host.rd(decode_offset, rd_data, resp);
        chk("read only", 32'h4a23, rd_data);
        $display("test refusals done");
        results();
    end
endmodule
bind lcd_display_config_decoder lcd_cfg_asserts u_lcd_cfg_asserts (.*);
`default_nettype wire
